/* File: dv/lds_far_end.sv */
// far-end partner: serial receiver for tx lines, serial source for rx lines
`timescale 1ns/1ps
`default_nettype none
module lds_far_end #(
  parameter int CH = 2,
  parameter int J  = 8
) (
  input  wire logic           core_clk,
  input  wire logic [CH-1:0]  tx_line,
  output logic [CH-1:0]       rx_line,
  output logic [CH-1:0][63:0] rx_hist,
  output logic [CH*J-1:0]     got_data,
  output logic                got_tog
);
  logic [CH-1:0]        live;
  logic [CH-1:0][J-1:0] sh;
  int                   cnt;
  initial begin
    rx_line = '0;
    rx_hist = '0;
    got_data = '0;
    got_tog = 1'b0;
    live = '0;
    sh = '0;
    cnt = 0;
  end
  // late-phase sample 45 ns into each 50 ns level, one bit per clock level
  always @(core_clk) begin
    #45;
    for (int c = 0; c < CH; c++) begin
      if (tx_line[c] === 1'b1) live[c] = 1'b1;
      if (live[c]) sh[c] = {sh[c][J-2:0], tx_line[c]};
    end
    if (live[0]) cnt++;
    // framing starts at the first one seen, so that word is marked
    if (cnt == J) begin
      cnt = 0;
      for (int c = 0; c < CH; c++) got_data[c*J +: J] = sh[c];
      got_tog = ~got_tog;
    end
  end
  // new random bit every half cycle, newest history at bit 0
  always @(core_clk) begin
    #30;
    rx_line = CH'($urandom);
    for (int c = 0; c < CH; c++) rx_hist[c] = {rx_hist[c][62:0], rx_line[c]};
  end
endmodule // lds_far_end
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the double-rate serial link block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int CH = 2;
  localparam int J  = 8;
  localparam int B  = 4;
  localparam int TW = J;
  logic                core_clk;
  logic                rstn;
  logic                tx_valid;
  logic                tx_ready;
  logic                tx_outclk;
  logic                rx_valid;
  logic                got_tog;
  logic                oc_prev;
  logic [CH*TW-1:0]    tx_word;
  logic [CH-1:0]       tx_line;
  logic [CH-1:0]       rx_line;
  logic [CH*J-1:0]     rx_word;
  logic [CH*J-1:0]     got_data;
  logic [CH-1:0][63:0] rx_hist;
  logic [CH*TW-1:0]    exp_q[$];
  int fails, checks_done, cyc, last_take, last_rxv, ntake, nrxv, d, run, noc;
  localparam int J2 = 5;
  logic                tx_ready2;
  logic                rx_valid2;
  logic                got_tog2;
  logic [CH-1:0]       line2;
  logic [CH-1:0]       rx_line2;
  logic [CH*J2-1:0]    rx_word2;
  logic [2*CH*J2-1:0]  tx_word2;
  logic [2*CH*J2-1:0]  got_data2;
  logic [2*CH*J2-1:0]  exp_q2[$];
  int ntake2, last_take2, nrxv2, last_rxv2, gap2;

  lds_serdes #(.CH(CH), .J(J), .B(B), .HALF_CORE(1'b0)) dut (
    .core_clk(core_clk), .rstn(rstn), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_line(tx_line),
    .tx_outclk(tx_outclk), .rx_line(rx_line), .rx_word(rx_word),
    .rx_valid(rx_valid));
  lds_far_end #(.CH(CH), .J(J)) far (
    .core_clk(core_clk), .tx_line(tx_line), .rx_line(rx_line),
    .rx_hist(rx_hist), .got_data(got_data), .got_tog(got_tog));

  // odd J with the wide-word option: one 2J-bit word per J cycles
  lds_serdes #(.CH(CH), .J(J2), .B(B), .HALF_CORE(1'b1)) dut_odd (
    .core_clk(core_clk), .rstn(rstn), .tx_word(tx_word2),
    .tx_valid(tx_valid), .tx_ready(tx_ready2), .tx_line(line2),
    .tx_outclk(), .rx_line(rx_line2), .rx_word(rx_word2),
    .rx_valid(rx_valid2));
  lds_far_end #(.CH(CH), .J(2 * J2)) far_odd (
    .core_clk(core_clk), .tx_line(line2), .rx_line(rx_line2),
    .rx_hist(), .got_data(got_data2), .got_tog(got_tog2));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic lane_ok(input int k);
    lane_ok = 1'b1;
    for (int c = 0; c < CH; c++)
      if (rx_word[c*J +: J] !== rx_hist[c][k +: J]) lane_ok = 1'b0;
  endfunction

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // reset, then a continuous word stream with ready as the only throttle
  initial begin
    void'($urandom(32'h76df));
    {fails, checks_done, cyc, ntake, nrxv, run, noc} = '0;
    {ntake2, nrxv2, gap2} = '0;
    rstn = 1'b0;
    tx_valid = 1'b0;
    tx_word = '0;
    tx_word2 = '0;
    oc_prev = 1'b0;
    repeat (16) @(posedge core_clk);
    #10;
    rstn = 1'b1;
    tx_word = (CH*TW)'({$urandom, $urandom});
    tx_word[TW-1] = 1'b1;
    tx_word[2*TW-1] = 1'b1;
    tx_word2 = (2*CH*J2)'({$urandom, $urandom});
    tx_word2[2*J2-1] = 1'b1;
    tx_word2[4*J2-1] = 1'b1;
    tx_valid = 1'b1;
    repeat (400) @(posedge core_clk);
    chk(64'(ntake > 50), 64'd1, "tx takes");
    chk(64'(nrxv > 50), 64'd1, "rx words");
    chk(64'(noc > 50), 64'd1, "outclk edges");
    chk(64'(ntake2 > 50), 64'd1, "wide takes");
    chk(64'(nrxv2 > 50), 64'd1, "odd rx words");
    give_verdict();
  end

  // cycle count by non-blocking update so every reader sees one value
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      fails++;
      give_verdict();
    end
  end

  // note each taken word; steady spacing is TW/2 fast cycles
  always @(posedge core_clk) begin
    if (rstn && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      exp_q.push_back(tx_word);
      ntake++;
      if (ntake > 2) chk(64'(cyc - last_take), 64'(TW / 2), "take gap");
      last_take = cyc;
      #10;
      tx_word = (CH*TW)'({$urandom, $urandom});
    end
  end

  // wide words: one take every J fast cycles, noted like the narrow ones
  always @(posedge core_clk) begin
    if (rstn && tx_valid === 1'b1 && tx_ready2 === 1'b1) begin
      exp_q2.push_back(tx_word2);
      ntake2++;
      if (ntake2 > 1)
        chk(64'(cyc - last_take2), 64'(J2), "wide take gap");
      last_take2 = cyc;
      #10;
      tx_word2 = (2*CH*J2)'({$urandom, $urandom});
    end
  end

  // rebuilt wide word against the oldest wide note
  always @(got_tog2) begin
    if (rstn === 1'b1) begin
      if (exp_q2.size() == 0)
        chk(64'(got_data2), 64'hbad, "extra wide");
      else
        chk(64'(got_data2), 64'(exp_q2.pop_front()), "wide tx");
    end
  end

  // odd J: short and long gaps alternate and two of them make J cycles
  always @(posedge core_clk) begin
    if (rstn && rx_valid2 === 1'b1) begin
      nrxv2++;
      if (nrxv2 > 2)
        chk(64'(cyc - last_rxv2 + gap2), 64'(J2), "odd rx gaps");
      gap2 = cyc - last_rxv2;
      last_rxv2 = cyc;
    end
  end

  // rebuilt line word against the oldest note
  always @(got_tog) begin
    if (rstn === 1'b1) begin
      if (exp_q.size() == 0) chk(64'(got_data), 64'hbad, "extra word");
      else chk(64'(got_data), 64'(exp_q.pop_front()), "tx word");
    end
  end

  // rx framing is free at release; lock once, then it must never slip
  always @(posedge core_clk) begin
    if (rstn && rx_valid === 1'b1) begin
      nrxv++;
      // the first word still carries reset zeros, so lock on the second
      if (nrxv == 2) begin
        d = -1;
        for (int k = 63 - J; k >= 0; k--)
          if (lane_ok(k)) d = k;
        chk(64'(d >= 0), 64'd1, "rx lock");
      end else if (nrxv > 2) begin
        chk(64'(cyc - last_rxv), 64'(J / 2), "rx gap");
        chk(64'(lane_ok(d)), 64'd1, "rx word");
      end
      last_rxv = cyc;
    end
  end

  // forwarded clock: each level lasts B half cycles, high first
  always @(core_clk) begin
    #45;
    if (rstn === 1'b1) begin
      if (tx_outclk !== oc_prev) begin
        if (noc > 0) chk(64'(run), 64'(B), "outclk run");
        else chk(64'(tx_outclk), 64'd1, "outclk start");
        noc++;
        run = 1;
      end else run++;
      oc_prev = tx_outclk;
    end
  end
endmodule // testbench
`default_nettype wire

/* File: logic/lds_ddr_io.sv */
// double-rate pin register lanes, output and input directions
`timescale 1ns/1ps
`default_nettype none
module lds_ddr_io #(
  parameter int TXW = 3,
  parameter int RXW = 2
) (
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  input  wire lds_pkg::lds_pair_s [TXW-1:0] tx_pair,
  output logic          [TXW-1:0]      tx_pin,
  input  wire logic     [RXW-1:0]      rx_pin,
  output lds_pkg::lds_pair_s [RXW-1:0] rx_pair
);
  lds_pkg::lds_pair_s [TXW-1:0] tx_q;
  logic [RXW-1:0] rise_q;
  logic [RXW-1:0] fall_q;

  // launch both bits of a pair on the rising edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_pair;
    end
  end

  // high phase shows hi, low phase lo: one bit per clock edge
  genvar g;
  generate
    for (g = 0; g < TXW; g++) begin : g_tx
      assign tx_pin[g] = core_clk ? tx_q[g].hi : tx_q[g].lo;
    end
  endgenerate

  // catch the pins on both edges
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rise_q <= '0;
    end else begin
      rise_q <= rx_pin;
    end
  end

  always_ff @(negedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fall_q <= '0;
    end else begin
      fall_q <= rx_pin;
    end
  end

  // realign the falling capture into the rising domain as a pair
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_pair <= '0;
    end else begin
      for (int i = 0; i < RXW; i++) begin
        rx_pair[i].hi <= rise_q[i];
        rx_pair[i].lo <= fall_q[i];
      end
    end
  end
endmodule : lds_ddr_io
`default_nettype wire

/* File: logic/lds_pkg.sv */
// shared types and constants for the double-rate serial link block
`default_nettype none
package lds_pkg;
  // core_clk is the fast clock; two line bits move per cycle
  localparam int CLK_PERIOD_NS   = 100;
  localparam int BITS_PER_CYCLE  = 2;
  localparam int DEF_CHANNELS    = 2;
  localparam int DEF_SER_FACTOR  = 8;
  localparam int DEF_OUTCLK_DIV  = 4;
  localparam logic RST_BIT       = 1'b0;
  localparam logic [3:0] RST_PHASE = 4'h0;
  // one bit pair as it sits in a double-rate register
  typedef struct packed {
    logic hi;  // bit sent or caught in the high phase
    logic lo;  // bit sent or caught in the low phase
  } lds_pair_s;
endpackage : lds_pkg
`default_nettype wire

/* File: logic/lds_serdes.sv */
// soft serializer and deserializer on double-rate pin registers
`timescale 1ns/1ps
`default_nettype none
module lds_serdes #(
  parameter int CH       = lds_pkg::DEF_CHANNELS,
  parameter int J        = lds_pkg::DEF_SER_FACTOR,
  parameter int B        = lds_pkg::DEF_OUTCLK_DIV,
  parameter bit HALF_CORE = 1'b0,
  localparam int TW      = (HALF_CORE && (J % 2 == 1)) ? 2 * J : J
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic [CH*TW-1:0]  tx_word,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  output logic [CH-1:0]          tx_line,
  output logic                   tx_outclk,
  input  wire logic [CH-1:0]     rx_line,
  output logic [CH*J-1:0]        rx_word,
  output logic                   rx_valid
);
  localparam int BUFW = TW + 2;
  localparam int CW   = $clog2(BUFW + 1);
  localparam int RW   = J + 1;
  localparam int RCW  = $clog2(RW + 2);
  localparam int PW   = $clog2(2 * B + 1);

  logic [CH-1:0][BUFW-1:0] tx_buf;
  logic [CW-1:0]           tx_cnt;
  logic [CW-1:0]           avail;
  logic                    take;
  logic [CH-1:0][RW-1:0]   rx_sr;
  logic [RCW-1:0]          rx_cnt;
  logic [RCW-1:0]          rx_sum;
  logic [PW-1:0]           oc_phase;
  lds_pkg::lds_pair_s [CH:0]   tx_pair;
  lds_pkg::lds_pair_s [CH-1:0] rx_pair;
  lds_pkg::lds_pair_s [CH-1:0] rx_s1;
  lds_pkg::lds_pair_s [CH-1:0] rx_s2;
  logic [CH:0]             tx_pins;

  // bits left after this cycle's two go out
  assign avail = (tx_cnt >= CW'(2)) ? tx_cnt - CW'(2) : tx_cnt;
  // ask for a word only when fewer than two bits would remain
  assign tx_ready = (avail < CW'(2));
  assign take     = tx_valid && tx_ready;

  // fill level: minus two per cycle, plus a word when taken
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_cnt <= '0;
    end else begin
      tx_cnt <= avail + (take ? CW'(TW) : CW'(0));
    end
  end

  // left-aligned buffer; the new word lands right behind leftovers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_buf <= '0;
    end else begin
      for (int c = 0; c < CH; c++) begin
        logic [BUFW-1:0] sh;
        logic [BUFW-1:0] ins;
        sh  = (tx_cnt >= CW'(2)) ? (tx_buf[c] << 2) : tx_buf[c];
        ins = {tx_word[c*TW +: TW], 2'b00};
        if (take) begin
          sh = sh | (ins >> avail);
        end
        tx_buf[c] <= sh;
      end
    end
  end

  // forwarded clock pattern: 2B half-cycles, high for the first B
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      oc_phase <= '0;
    end else if (oc_phase >= PW'(2 * B - 2)) begin
      oc_phase <= PW'(oc_phase + PW'(2) - PW'(2 * B));
    end else begin
      oc_phase <= oc_phase + PW'(2);
    end
  end

  // starving lanes send zeros rather than stale bits
  always_comb begin
    for (int c = 0; c < CH; c++) begin
      tx_pair[c].hi = (tx_cnt >= CW'(2)) && tx_buf[c][BUFW-1];
      tx_pair[c].lo = (tx_cnt >= CW'(2)) && tx_buf[c][BUFW-2];
    end
    tx_pair[CH].hi = (oc_phase < PW'(B));
    tx_pair[CH].lo = (oc_phase + PW'(1) < PW'(B));
  end

  // pin lanes: channels plus the forwarded clock lane on top
  lds_ddr_io #(
    .TXW (CH + 1),
    .RXW (CH)
  ) u_pins (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tx_pair  (tx_pair),
    .tx_pin   (tx_pins),
    .rx_pin   (rx_line),
    .rx_pair  (rx_pair)
  );

  assign tx_line   = tx_pins[CH-1:0];
  assign tx_outclk = tx_pins[CH];

  // two-stage resync of the caught pairs; stage one feeds only stage two
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_s1 <= '0;
      rx_s2 <= '0;
    end else begin
      rx_s1 <= rx_pair;
      rx_s2 <= rx_s1;
    end
  end

  assign rx_sum = rx_cnt + RCW'(2);

  // gather two bits a cycle, emit when J are held
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_cnt <= '0;
    end else if (rx_sum >= RCW'(J)) begin
      rx_cnt <= rx_sum - RCW'(J);
    end else begin
      rx_cnt <= rx_sum;
    end
  end

  // word framing is fixed from reset; there is no alignment search
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_sr <= '0;
    end else begin
      for (int c = 0; c < CH; c++) begin
        rx_sr[c] <= {rx_sr[c][RW-3:0], rx_s2[c].hi, rx_s2[c].lo};
      end
    end
  end

  // oldest bit lands in the word's top bit
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_word  <= '0;
      rx_valid <= lds_pkg::RST_BIT;
    end else begin
      rx_valid <= (rx_sum >= RCW'(J));
      if (rx_sum >= RCW'(J)) begin
        for (int c = 0; c < CH; c++) begin
          logic [RW+1:0] full;
          full = {rx_sr[c], rx_s2[c].hi, rx_s2[c].lo};
          rx_word[c*J +: J] <= J'(full >> (rx_sum - RCW'(J)));
        end
      end
    end
  end

  // checks
  logic [7:0] take_gap;
  logic [7:0] rx_gap;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      take_gap <= '0;
      rx_gap   <= '0;
    end else begin
      take_gap <= take ? 8'h00 : take_gap + 8'h01;
      rx_gap   <= (rx_sum >= RCW'(J)) ? 8'h00 : rx_gap + 8'h01;
    end
  end

  ddr_two_bits_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (tx_cnt >= CW'(2)) && !take |=> tx_cnt == $past(tx_cnt) - CW'(2))
    else $error("tx level not dropping by two per cycle");
  word_take_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    take |=> tx_cnt == $past(avail) + CW'(TW))
    else $error("tx word not added to level");
  tx_no_overfill_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    tx_cnt <= CW'(BUFW))
    else $error("tx buffer overfilled");
  // a word of four or more bits outlasts one cycle, so takes never touch
  tx_rate_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    take && TW > 3 |=> !take)
    else $error("tx words taken faster than the line drains");
  tx_gap_bound_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    tx_valid && take_gap > 8'(TW / 2) |-> take)
    else $error("tx word starved with data offered");
  outclk_half_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    oc_phase < PW'(2 * B))
    else $error("outclock phase out of range");
  outclk_high_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    oc_phase == PW'(0) |-> tx_pair[CH].hi)
    else $error("outclock not high at period start");
  rx_rate_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    rx_gap <= 8'((J + 1) / 2))
    else $error("rx word spacing too long");
  // with J of three a word can complete on two cycles in a row
  rx_valid_pulse_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    rx_valid && J > 3 |=> !rx_valid)
    else $error("rx valid held past one cycle");

  tx_take_c: cover property (@(posedge core_clk) disable iff (!rstn)
    take ##[1:16] take);
  rx_word_c: cover property (@(posedge core_clk) disable iff (!rstn)
    rx_valid ##[1:16] rx_valid);
  tx_starve_c: cover property (@(posedge core_clk) disable iff (!rstn)
    tx_ready && !tx_valid);
  outclk_wrap_c: cover property (@(posedge core_clk) disable iff (!rstn)
    oc_phase == PW'(0) ##1 oc_phase != PW'(0));
endmodule : lds_serdes
`default_nettype wire
